// ===== port_pin_pkg.sv
// constants, types and the port register map for the configurable port pin block
// Overview of operation
// - two mode bits per port: 00 quasi, 01 push-pull, 10 input-only, 11 open-drain
// - mode register: port3 bits 7:6, port2 5:4, port1 3:2, port0 1:0
// - tristate fuse enabled: ports 0-3 come out of reset input-only
// - fuse disabled: ports 1-3 quasi and pulled high, port 0 open-drain
// - port 4 is always quasi-bidirectional whatever fuse or mode register say
// - power-down gates all input buffers except both irq pins and both osc pins
// - quasi: very weak pull-up is on whenever the latch bit is one
// - quasi: weak pull-up on only while latch bit and sensed pin are both one
// - quasi: latch bit rising zero to one gives exactly one cycle of strong pull-up
// - latch bit zero in quasi, open-drain or push-pull drives the pin low strongly
// - input-only: drivers and every pull-up off, pin left floating
// - open-drain: no pull-ups, pull-down only while latch bit is zero
// - push-pull: continuous strong pull-up while the latch bit is one
// - plain port read returns sensed pin levels, not the latch
// - read-modify-write reads return the latch contents
// - single-bit write reads the latch byte, changes one bit, writes it back
// - 34 to 40 pins free: osc pins freed by RC osc, strobes take pins
// - each alternate function output is ANDed with the pin's latch bit
// - external bus owns port 0 and port 2 direction, mode bits ignored
package port_pin_pkg;

	// register addresses
	localparam logic [7:0] ADDR_PORT0      = 8'h80;
	localparam logic [7:0] ADDR_PORT1      = 8'h90;
	localparam logic [7:0] ADDR_PORT2      = 8'hA0;
	localparam logic [7:0] ADDR_PORT3      = 8'hB0;
	localparam logic [7:0] ADDR_PORT4      = 8'hD8;
	localparam logic [7:0] ADDR_PORT_MODE  = 8'hC1;

	// reset values
	localparam logic [7:0] MODE_RST_NORMAL = 8'h03;
	localparam logic [7:0] MODE_RST_TRIST  = 8'hAA;
	localparam logic [7:0] LATCH_RST       = 8'hFF;
	localparam logic [7:0] RDATA_UNMAPPED  = 8'h00;

	// field layout of the mode register
	localparam int MODE_FIELD_W = 2;
	localparam int NUM_PORTS    = 5;
	localparam int PIN_W        = 8;
	localparam int ALL_PINS     = NUM_PORTS * PIN_W;

	// pins that keep their input buffer in power-down (flat index port*8+bit)
	localparam logic [39:0] PD_KEEP_MASK  = 40'hC0_0C00_0000;
	// oscillator pins on port 4 bits 6 and 7
	localparam int OSC_IN_IDX  = 38;
	localparam int OSC_OUT_IDX = 39;
	// strobe pins taken by the external bus (port 3 bits 6,7; port 4 bits 4,5)
	localparam logic [39:0] DATA_STROBE_MASK = 40'h20_C000_0000;
	localparam logic [39:0] PROG_STROBE_MASK = 40'h30_0000_0000;

	// port modes, encoded {high bit, low bit}
	typedef enum logic [1:0] {
		MODE_QUASI  = 2'h0,
		MODE_PUSH   = 2'h1,
		MODE_INPUT  = 2'h2,
		MODE_OPEN   = 2'h3
	} port_mode_t;

	// oscillator source
	typedef enum logic [1:0] {
		OSC_CRYSTAL = 2'h0,
		OSC_EXT_CLK = 2'h1,
		OSC_RC      = 2'h2
	} osc_src_t;

	// per pin drive controls, flat index port*8+bit
	typedef struct packed {
		logic [39:0] oe;       // strong driver enabled
		logic [39:0] out;      // strong driver level
		logic [39:0] pu_weak;  // weak pull-up
		logic [39:0] pu_vweak; // very weak pull-up
		logic [39:0] in_en;    // input buffer enabled
	} pin_drive_t;

	// external memory bus request
	typedef struct packed {
		logic       active;
		logic       prog;     // program fetch in use
		logic       data;     // data read/write in use
		logic       p0_oe;
		logic [7:0] p0_out;
		logic [7:0] p2_out;
	} ext_bus_t;

endpackage : port_pin_pkg

// ===== pin_sync.sv
// two-flop synchroniser for the port pin levels
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 40
) (
	// clock and reset
	input  wire logic             i_clk_sys,
	input  wire logic             i_rst_b,
	// levels
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	// first stage feeds only the second
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;

endmodule : pin_sync

// ===== port_pin_ctrl.sv
// configurable port pin control: latches, mode register and per pin drivers
`timescale 1ns/1ps
module port_pin_ctrl
	import port_pin_pkg::*;
#(
	parameter int PORTS = NUM_PORTS
) (
	// clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst_b,
	// register port
	input  wire logic [7:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	input  wire logic        i_rd_latch,
	input  wire logic        i_bit_wr,
	input  wire logic [2:0]  i_bit_idx,
	input  wire logic        i_bit_val,
	output logic      [7:0]  o_rdata,
	// configuration and power
	input  wire logic        i_fuse_tristate,
	input  wire logic        i_pwr_down,
	input  wire logic [1:0]  i_osc_src,
	// peripherals and external bus
	input  wire logic [39:0] i_alt_out,
	input  wire ext_bus_t    i_bus,
	// pins
	input  wire logic [39:0] i_pin,
	output pin_drive_t       o_drive,
	output logic      [39:0] o_pin_sensed,
	output logic      [39:0] o_pin_avail
);

	// the flat pin maps are laid out for exactly five ports
	if (PORTS != NUM_PORTS) begin : g_bad_ports
		$error("port_pin_ctrl supports five ports only");
	end

	// mode of one port; port 4 is fixed
	function automatic port_mode_t port_mode(input logic [7:0] mreg, input int p);
		port_mode_t m;
		m = MODE_QUASI;
		if (p < 4) begin
			m = port_mode_t'(mreg[p*MODE_FIELD_W +: MODE_FIELD_W]);
		end
		return m;
	endfunction : port_mode

	// address to latch index, or 7 for none
	function automatic logic [2:0] port_sel(input logic [7:0] a);
		logic [2:0] s;
		s = 3'h7;
		unique case (a)
			ADDR_PORT0: s = 3'h0;
			ADDR_PORT1: s = 3'h1;
			ADDR_PORT2: s = 3'h2;
			ADDR_PORT3: s = 3'h3;
			ADDR_PORT4: s = 3'h4;
			default:    s = 3'h7;
		endcase
		return s;
	endfunction : port_sel

	// registers
	logic [7:0]  mode_q;
	logic [39:0] latch_q;
	logic [39:0] latch_d;
	logic [39:0] eff_prev_q;
	logic [7:0]  rdata_q;
	logic [7:0]  rdata_d;
	pin_drive_t  drive_q;
	pin_drive_t  drive_d;
	logic [39:0] sensed_q;
	logic [39:0] avail_q;
	logic [39:0] avail_d;

	// synchronised pin levels
	logic [39:0] pin_sync_lvl;

	pin_sync #(
		.WIDTH (ALL_PINS)
	) u_pin_sync (
		.i_clk_sys (i_clk_sys),
		.i_rst_b   (i_rst_b),
		.i_async   (i_pin),
		.o_sync    (pin_sync_lvl)
	);

	// register access decode
	wire logic [2:0] wr_sel    = port_sel(i_addr);
	wire logic       wr_port   = i_wr && (wr_sel != 3'h7);
	wire logic       wr_mode   = i_wr && (i_addr == ADDR_PORT_MODE);
	wire logic       bit_port  = i_bit_wr && (wr_sel != 3'h7);
	wire logic [5:0] byte_base = {wr_sel, 3'h0};
	wire logic [7:0] cur_latch = (wr_sel != 3'h7) ? latch_q[byte_base +: 8] : 8'h00;

	// single-bit write: whole latch byte read, one bit changed, written back
	logic [7:0] bit_merged;
	always_comb begin
		bit_merged            = cur_latch;
		bit_merged[i_bit_idx] = i_bit_val;
	end

	// next latch contents
	always_comb begin
		latch_d = latch_q;
		if (wr_port) begin
			latch_d[byte_base +: 8] = i_wdata;
		end else if (bit_port) begin
			latch_d[byte_base +: 8] = bit_merged;
		end
	end

	// read data: plain reads see the pins, read-modify-write sees the latch
	wire logic [7:0] pin_byte = (wr_sel != 3'h7) ? sensed_q[byte_base +: 8] : 8'h00;
	always_comb begin
		rdata_d = RDATA_UNMAPPED;
		if (i_rd && (i_addr == ADDR_PORT_MODE)) begin
			rdata_d = mode_q;
		end else if (i_rd && (wr_sel != 3'h7)) begin
			rdata_d = i_rd_latch ? cur_latch : pin_byte;
		end
	end

	// latch and mode register
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			latch_q <= {ALL_PINS{1'b1}} & {5{LATCH_RST}};
		end else begin
			latch_q <= latch_d;
		end
	end

	// the fuse is read at reset; a mode write takes over afterwards
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			mode_q <= i_fuse_tristate ? MODE_RST_TRIST : MODE_RST_NORMAL;
		end else if (wr_mode) begin
			mode_q <= i_wdata;
		end
	end

	// effective output bit: latch gated by the alternate function
	wire logic [39:0] eff_out  = latch_q & i_alt_out;
	wire logic [39:0] eff_rise = eff_out & ~eff_prev_q;

	// pins that the oscillator or the external bus strobes keep
	always_comb begin
		avail_d = {ALL_PINS{1'b1}};
		if (osc_src_t'(i_osc_src) != OSC_RC) begin
			avail_d[OSC_OUT_IDX] = 1'b0;
		end
		if (osc_src_t'(i_osc_src) == OSC_CRYSTAL) begin
			avail_d[OSC_IN_IDX] = 1'b0;
		end
		if (i_bus.active && i_bus.prog) begin
			avail_d = avail_d & ~PROG_STROBE_MASK;
		end
		if (i_bus.active && i_bus.data) begin
			avail_d = avail_d & ~DATA_STROBE_MASK;
		end
	end

	// input buffers gated in power-down
	wire logic [39:0] in_en_d = i_pwr_down ? PD_KEEP_MASK : {ALL_PINS{1'b1}};
	wire logic [39:0] sensed_d = pin_sync_lvl & in_en_d;

	// per pin drive decision
	always_comb begin
		port_mode_t m;
		int         i;
		m       = MODE_QUASI;
		i       = 0;
		drive_d = '0;
		drive_d.in_en = in_en_d;
		for (int p = 0; p < NUM_PORTS; p++) begin
			m = port_mode(mode_q, p);
			for (int b = 0; b < PIN_W; b++) begin
				i = p * PIN_W + b;
				unique case (m)
					MODE_QUASI: begin
						drive_d.oe[i]       = ~eff_out[i] | eff_rise[i];
						drive_d.out[i]      = eff_rise[i];
						drive_d.pu_vweak[i] = eff_out[i];
						drive_d.pu_weak[i]  = eff_out[i] & sensed_q[i];
					end
					MODE_PUSH: begin
						drive_d.oe[i]  = 1'b1;
						drive_d.out[i] = eff_out[i];
					end
					MODE_INPUT: begin
						drive_d.oe[i] = 1'b0;
					end
					MODE_OPEN: begin
						drive_d.oe[i]  = ~eff_out[i];
						drive_d.out[i] = 1'b0;
					end
				endcase
			end
		end
		// external bus owns port 2 as address out and port 0 as address/data
		if (i_bus.active) begin
			for (int b = 0; b < PIN_W; b++) begin
				drive_d.oe[2*PIN_W+b]       = 1'b1;
				drive_d.out[2*PIN_W+b]      = i_bus.p2_out[b];
				drive_d.pu_weak[2*PIN_W+b]  = 1'b0;
				drive_d.pu_vweak[2*PIN_W+b] = 1'b0;
				drive_d.oe[b]               = i_bus.p0_oe;
				drive_d.out[b]              = i_bus.p0_out[b];
				drive_d.pu_weak[b]          = 1'b0;
				drive_d.pu_vweak[b]         = 1'b0;
			end
		end
		// pins held by the oscillator or the bus strobes are released here
		drive_d.oe       = drive_d.oe & avail_d;
		drive_d.out      = drive_d.out & avail_d;
		drive_d.pu_weak  = drive_d.pu_weak & avail_d;
		drive_d.pu_vweak = drive_d.pu_vweak & avail_d;
	end

	// output and history registers
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			eff_prev_q <= '1;
			rdata_q    <= RDATA_UNMAPPED;
			drive_q    <= '0;
			sensed_q   <= '0;
			avail_q    <= '0;
		end else begin
			eff_prev_q <= eff_out;
			rdata_q    <= rdata_d;
			drive_q    <= drive_d;
			sensed_q   <= sensed_d;
			avail_q    <= avail_d;
		end
	end

	assign o_rdata      = rdata_q;
	assign o_drive      = drive_q;
	assign o_pin_sensed = sensed_q;
	assign o_pin_avail  = avail_q;

endmodule : port_pin_ctrl

// ===== port_pin_monitor.sv
// assertion checker for the port pin control block
`timescale 1ns/1ps
module port_pin_monitor
	import port_pin_pkg::*;
(
	// watched ports
	input wire logic       i_clk_sys,
	input wire logic       i_rst_b,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic       i_wr,
	input wire logic       i_rd,
	input wire logic       i_fuse_tristate,
	input wire logic       i_pwr_down,
	input wire logic [7:0] o_rdata,
	input wire pin_drive_t o_drive
);
	logic [7:0] mode_q;
	logic [1:0] p1_mode;
	// shadow of the mode register, port 1 field picked out
	assign p1_mode = mode_q[3:2];
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b)
			mode_q <= i_fuse_tristate ? MODE_RST_TRIST : MODE_RST_NORMAL;
		else if (i_wr && i_addr == ADDR_PORT_MODE)
			mode_q <= i_wdata;
	end
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);
	a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data outside read slot");
	a_mode_readback: assert property ($past(i_rd) && $past(i_addr) == ADDR_PORT_MODE
		|-> o_rdata == $past(mode_q)) else $error("mode register readback wrong");
	a_strong_once: assert property (o_drive.oe[32] && o_drive.out[32]
		|=> !(o_drive.oe[32] && o_drive.out[32])) else $error("strong pull-up too long");
	a_weak_needs_latch: assert property ((o_drive.pu_weak & ~o_drive.pu_vweak) == 40'h0)
		else $error("weak pull-up without very weak one");
	a_input_off: assert property ($past(p1_mode) == MODE_INPUT |->
		(o_drive.oe[15:8] | o_drive.pu_weak[15:8] | o_drive.pu_vweak[15:8]) == 8'h00)
		else $error("input-only port drives");
	a_open_nopull: assert property ($past(p1_mode) == MODE_OPEN |-> (o_drive.pu_weak[15:8]
		| o_drive.pu_vweak[15:8] | (o_drive.oe[15:8] & o_drive.out[15:8])) == 8'h00)
		else $error("open-drain port pulls up");
	a_push_drive: assert property ($past(p1_mode) == MODE_PUSH |-> o_drive.oe[15:8] == 8'hFF)
		else $error("push-pull port not driven");
	a_pd_gate: assert property ($past(i_pwr_down) |-> (o_drive.in_en & ~PD_KEEP_MASK) == 40'h0)
		else $error("input buffer on in power-down");
	c_pulse: cover property (o_drive.oe[32] && o_drive.out[32]);
	c_push: cover property ($past(p1_mode) == MODE_PUSH);
	c_pd: cover property ($past(i_pwr_down));
endmodule : port_pin_monitor

// ===== pin_partner.sv
// outside devices on the pins: commanded pull-downs, floating pins wander
`timescale 1ns/1ps
module pin_partner
	import port_pin_pkg::*;
(
	// clock
	input  wire logic        i_clk_sys,
	// drive from the block and from outside devices
	input  wire pin_drive_t  i_drive,
	input  wire logic [39:0] i_ext_low,
	output logic      [39:0] o_pin
);
	logic tog_q = 1'b0;
	// an undriven pin with no pull toggles so a stale level is never read
	always_ff @(posedge i_clk_sys) tog_q <= ~tog_q;
	assign o_pin = (i_drive.oe & i_drive.out) | (~i_drive.oe & ~i_ext_low
		& (i_drive.pu_weak | i_drive.pu_vweak | {40{tog_q}}));
endmodule : pin_partner

// ===== configurable_port_pin_control_test.sv
// self-checking bench for the port pin control block
`timescale 1ns/1ps
module configurable_port_pin_control_test
	import port_pin_pkg::*;
;
	logic clk = 1'b0, i_rst_b = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_rd_latch = 1'b0;
	logic i_bit_wr = 1'b0, i_bit_val = 1'b0, i_fuse_tristate = 1'b0, i_pwr_down = 1'b0;
	logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata, ev;
	logic [2:0] i_bit_idx = 3'h0;
	logic [1:0] i_osc_src = OSC_RC;
	logic [39:0] ext_low = 40'h0, pin, sensed, avail;
	logic [39:0] alt = '1;
	ext_bus_t bus = '0;
	logic [31:0] seed = 32'h32C2;
	logic [7:0] q[$];
	logic rd_pend;
	pin_drive_t drv;
	int fails = 0, comparisons = 0;
	logic [7:0] oe_exp [4] = '{8'hF0, 8'hFF, 8'h00, 8'hF0};
	logic [7:0] hi_exp [4] = '{8'h00, 8'h0F, 8'h00, 8'h00};
	port_pin_ctrl uut (.i_clk_sys(clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .i_rd_latch(i_rd_latch), .i_bit_wr(i_bit_wr),
		.i_bit_idx(i_bit_idx), .i_bit_val(i_bit_val), .o_rdata(o_rdata),
		.i_fuse_tristate(i_fuse_tristate), .i_pwr_down(i_pwr_down), .i_osc_src(i_osc_src),
		.i_alt_out(alt), .i_bus(bus), .i_pin(pin), .o_drive(drv),
		.o_pin_sensed(sensed), .o_pin_avail(avail));
	pin_partner far (.i_clk_sys(clk), .i_drive(drv), .i_ext_low(ext_low), .o_pin(pin));
	// clock
	initial begin
		forever #4 clk = ~clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	task automatic do_reset(input logic f);
		i_rst_b <= 1'b0;
		i_fuse_tristate <= f;
		repeat (12) @(posedge clk);
		i_rst_b <= 1'b1;
		@(posedge clk);
	endtask : do_reset
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge clk);
		i_wr <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic bwr(input logic [7:0] a, input logic [2:0] i, input logic v);
		i_addr <= a;
		i_bit_idx <= i;
		i_bit_val <= v;
		i_bit_wr <= 1'b1;
		@(posedge clk);
		i_bit_wr <= 1'b0;
		@(posedge clk);
	endtask : bwr
	task automatic rd(input logic [7:0] a, input logic l, input logic [7:0] e);
		i_addr <= a;
		i_rd_latch <= l;
		i_rd <= 1'b1;
		q.push_back(e);
		@(posedge clk);
		i_rd <= 1'b0;
		@(posedge clk);
	endtask : rd
	// read data stands only in the cycle after the strobe
	always @(posedge clk) rd_pend <= i_rd;
	always @(negedge clk) if (rd_pend) chk("rdata", q.pop_front(), o_rdata);
	// main sequence
	initial begin
		do_reset(1'b0);
		rd(ADDR_PORT_MODE, 1'b0, MODE_RST_NORMAL);
		rd(ADDR_PORT1, 1'b1, LATCH_RST);
		wr(ADDR_PORT1, 8'h0F);
		for (int m = 0; m < 4; m++) begin
			wr(ADDR_PORT_MODE, 8'(m << 2));
			rd(ADDR_PORT_MODE, 1'b0, 8'(m << 2));
			@(negedge clk);
			chk("oe", oe_exp[m], drv.oe[15:8]);
			chk("high", hi_exp[m], drv.oe[15:8] & drv.out[15:8]);
			chk("vweak", (m == 0) ? 8'h0F : 8'h00, drv.pu_vweak[15:8]);
			@(posedge clk);
		end
		$display("mode table done");
		wr(ADDR_PORT_MODE, MODE_RST_TRIST);
		wr(ADDR_PORT4, 8'h00);
		wr(ADDR_PORT4, 8'hFF);
		@(negedge clk);
		chk("strong", 8'hFF, drv.oe[39:32] & drv.out[39:32]);
		@(negedge clk);
		chk("strong", 8'h00, drv.oe[39:32] & drv.out[39:32]);
		@(posedge clk);
		ext_low <= 40'h01_0000_0000;
		repeat (5) @(posedge clk);
		@(negedge clk);
		chk("weak", 8'hFE, drv.pu_weak[39:32]);
		chk("vweak", 8'hFF, drv.pu_vweak[39:32]);
		@(posedge clk);
		rd(ADDR_PORT4, 1'b0, 8'hFE);
		rd(ADDR_PORT4, 1'b1, 8'hFF);
		// alternate function low on bit 32 forces a strong low there
		alt <= {8'hFE, 32'hFFFF_FFFF};
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk("alt", 8'h01, drv.oe[39:32] & ~drv.out[39:32]);
		@(posedge clk);
		alt <= '1;
		$display("quasi port done");
		for (int k = 0; k < 4; k++) begin
			seed = xs(seed);
			ev = seed[7:0];
			ev[seed[10:8]] = seed[11];
			wr(ADDR_PORT1, seed[7:0]);
			bwr(ADDR_PORT1, seed[10:8], seed[11]);
			rd(ADDR_PORT1, 1'b1, ev);
		end
		wr(8'h00, 8'h55);
		rd(8'h00, 1'b0, RDATA_UNMAPPED);
		rd(ADDR_PORT_MODE, 1'b0, MODE_RST_TRIST);
		$display("bit write done");
		// external bus takes port 0 and port 2 and both strobe groups
		bus <= ext_bus_t'{1'b1, 1'b1, 1'b1, 1'b1, 8'h5A, 8'hC3};
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk("p2oe", 8'hFF, drv.oe[23:16]);
		chk("p2", 8'hC3, drv.oe[23:16] & drv.out[23:16]);
		chk("p0oe", 8'hFF, drv.oe[7:0]);
		chk("p0", 8'h5A, drv.out[7:0]);
		chk("avail", 40'hCF_3FFF_FFFF, avail);
		@(posedge clk);
		bus <= '0;
		$display("alt and bus done");
		i_pwr_down <= 1'b1;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk("in_en", PD_KEEP_MASK, drv.in_en);
		chk("sensed", 40'h0, sensed & ~PD_KEEP_MASK);
		chk("avail", 2'h3, avail[39:38]);
		@(posedge clk);
		i_pwr_down <= 1'b0;
		i_osc_src <= OSC_CRYSTAL;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk("avail", 2'h0, avail[39:38]);
		$display("power and pins done");
		@(posedge clk);
		do_reset(1'b1);
		rd(ADDR_PORT_MODE, 1'b0, MODE_RST_TRIST);
		$display("fuse reset done");
		report_and_stop();
	end
	// hang guard
	initial begin
		#200000;
		fails++;
		report_and_stop();
	end
endmodule : configurable_port_pin_control_test
bind port_pin_ctrl port_pin_monitor mon (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
	.i_fuse_tristate(i_fuse_tristate), .i_pwr_down(i_pwr_down), .o_rdata(o_rdata),
	.o_drive(o_drive));
